// >>> include/dhw_params.svh
`ifndef DHW_PARAMS_SVH
`define DHW_PARAMS_SVH

// ****************************************
// per-unit register offsets (low five bits)
// ****************************************
`define DHW_UNIT_REGION 2'h0
`define DHW_OFS_AVAL 5'h00
`define DHW_OFS_AMSK 5'h04
`define DHW_OFS_DVAL 5'h08
`define DHW_OFS_DMSK 5'h0c
`define DHW_OFS_CVAL 5'h10
`define DHW_OFS_CMSK 5'h14
`define DHW_OFS_CFG 5'h18

// ****************************************
// global register offsets
// ****************************************
`define DHW_OFS_CTRL 8'h40
`define DHW_OFS_STAT 8'h44
`define DHW_OFS_IRQ_STAT 8'h48
`define DHW_OFS_IRQ_MASK 8'h4c

// ****************************************
// field positions and widths
// ****************************************
`define DHW_CFG_EN 0
`define DHW_CFG_FETCH 1
`define DHW_CTRL_HALT 0
`define DHW_CTRL_RESUME 1
`define DHW_STAT_DBG 0
`define DHW_STAT_CAUSE_LO 1
`define DHW_STAT_REQ 3
`define DHW_STAT_DPEND 4
`define DHW_IRQ_W 3
`define DHW_SCAN_WR 0
`define DHW_SCAN_ADDR_LO 1
`define DHW_SCAN_DATA_LO 9
`define DHW_SCAN_W 41

// ****************************************
// reset values
// ****************************************
`define DHW_RST_WORD 32'h0000_0000
`define DHW_RST_CFG 2'h0
`define DHW_RST_IRQ 3'h0

`endif

// >>> include/dhw_pkg.sv
package dhw_pkg;

	// ****************************************
	// core run state and halt cause
	// ****************************************
	typedef enum logic [1:0] {
		DHW_RUN = 2'b01,
		DHW_HALT = 2'b10
	} dhw_state_t;

	typedef enum logic [1:0] {
		DHW_CAUSE_NONE = 2'h0,
		DHW_CAUSE_FETCH = 2'h1,
		DHW_CAUSE_DATA = 2'h2,
		DHW_CAUSE_REQ = 2'h3
	} dhw_cause_t;

endpackage

// >>> include/dhw_wp_if.sv
`timescale 1ns/100ps
// settings of one watchpoint unit and its match answer
interface dhw_wp_if #(
	parameter int AW = 32,
	parameter int DW = 32,
	parameter int CW = 4
);
	logic [AW-1:0] addrVal;
	logic [AW-1:0] addrMask;
	logic [DW-1:0] dataVal;
	logic [DW-1:0] dataMask;
	logic [CW-1:0] ctrlVal;
	logic [CW-1:0] ctrlMask;
	logic enable;
	logic fetchMode;
	logic match;

	modport ctl (
		output addrVal, addrMask, dataVal, dataMask,
		output ctrlVal, ctrlMask, enable, fetchMode,
		input match
	);
	modport unit (
		input addrVal, addrMask, dataVal, dataMask,
		input ctrlVal, ctrlMask, enable, fetchMode,
		output match
	);
endinterface

// >>> rtl/dhw_wp_match.sv
`timescale 1ns/100ps
module dhw_wp_match #(
	parameter int AW = 32,
	parameter int DW = 32,
	parameter int CW = 4
) (
	input wire logic accValid, // access on the bus this cycle
	input wire logic accFetch, // access is an instruction fetch
	input wire logic [AW-1:0] accAddr, // access address
	input wire logic [DW-1:0] accData, // access data
	input wire logic [CW-1:0] accCtrl, // access control signals
	dhw_wp_if.unit cfg // unit settings and match
);

	logic addrEq;
	logic dataEq;
	logic ctrlEq;
	logic kindEq;
	logic hit;

	// masked compare: a set mask bit drops that bit
	always_comb begin
		addrEq = ((accAddr ^ cfg.addrVal) & ~cfg.addrMask) == '0;
		dataEq = ((accData ^ cfg.dataVal) & ~cfg.dataMask) == '0;
		ctrlEq = ((accCtrl ^ cfg.ctrlVal) & ~cfg.ctrlMask) == '0;
		kindEq = (cfg.fetchMode == accFetch);
		hit = accValid & cfg.enable & kindEq
			& addrEq & dataEq & ctrlEq;
	end

	assign cfg.match = hit;

endmodule

// >>> rtl/dhw_debug_unit.sv
// The Avalon-MM interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "dhw_params.svh"

module dhw_debug_unit
	import dhw_pkg::*;
#(
	parameter int AW = 32,
	parameter int DW = 32,
	parameter int CW = 4
) (
	input wire logic ref_clk, // block clock
	input wire logic reset_n, // synchronous reset
	input wire logic [7:0] avs_address, // byte address
	input wire logic avs_read, // read strobe
	input wire logic avs_write, // write strobe
	input wire logic [31:0] avs_writedata, // write data
	output logic [31:0] avs_readdata, // read data
	output logic avs_waitrequest, // stall
	output logic irq, // level interrupt
	input wire logic jtagTck, // test port clock
	input wire logic jtagTms, // test port mode select
	input wire logic jtagTdi, // test port data in
	output logic jtagTdo, // test port data out
	input wire logic accValid, // core access valid
	input wire logic accFetch, // core access is a fetch
	input wire logic [AW-1:0] accAddr, // core access address
	input wire logic [DW-1:0] accData, // core access data
	input wire logic [CW-1:0] accCtrl, // core control signals
	input wire logic pipeAdvance, // pipeline steps one stage
	input wire logic pipeFlush, // fetched instructions discarded
	input wire logic instrDone, // executing instruction completes
	input wire logic debug_request_in, // external halt request
	output logic breakpoint_tag_in, // tag toward the core
	output logic debug_acknowledge_out // core in debug state
);

	localparam int NU = 2;

	// ****************************************
	// declarations
	// ****************************************
	logic [AW-1:0] aval_reg [NU];
	logic [AW-1:0] aval_next [NU];
	logic [AW-1:0] amsk_reg [NU];
	logic [AW-1:0] amsk_next [NU];
	logic [DW-1:0] dval_reg [NU];
	logic [DW-1:0] dval_next [NU];
	logic [DW-1:0] dmsk_reg [NU];
	logic [DW-1:0] dmsk_next [NU];
	logic [CW-1:0] cval_reg [NU];
	logic [CW-1:0] cval_next [NU];
	logic [CW-1:0] cmsk_reg [NU];
	logic [CW-1:0] cmsk_next [NU];
	logic [1:0] cfg_reg [NU];
	logic [1:0] cfg_next [NU];
	logic ctrlHalt_reg, ctrlHalt_next;
	logic [`DHW_IRQ_W-1:0] irqStat_reg, irqStat_next;
	logic [`DHW_IRQ_W-1:0] irqMask_reg, irqMask_next;
	logic [`DHW_IRQ_W-1:0] irqSet;
	logic [`DHW_IRQ_W-1:0] irqClr;
	logic [3:0] pinMeta_reg, pinMeta_next;
	logic [3:0] pinSync_reg, pinSync_next;
	logic tckPrev_reg, tckPrev_next;
	logic [`DHW_SCAN_W-1:0] scan_reg, scan_next;
	logic [`DHW_SCAN_W-1:0] jtCmd_reg, jtCmd_next;
	logic jtPend_reg, jtPend_next;
	logic avAck_reg, avAck_next;
	logic [31:0] rdata_reg, rdata_next;
	dhw_state_t state_reg, state_next;
	dhw_cause_t cause_reg, cause_next;
	logic [2:0] tagPipe_reg, tagPipe_next;
	logic dataPend_reg, dataPend_next;
	logic [NU-1:0] unitHit;
	logic running, tckRise, haltReq, dbgReqSync;
	logic avWr, jtWr, wrEn, resumeReq, enterEvt;
	logic newFetch, newData;
	logic [7:0] wrAddr;
	logic [7:0] jtAddr;
	logic [31:0] wrData;
	logic [31:0] statusWord;

	dhw_wp_if #(.AW(AW), .DW(DW), .CW(CW)) wpIf [NU] ();

	// ****************************************
	// watchpoint units
	// ****************************************
	for (genvar g = 0; g < NU; g++) begin : gUnit
		assign wpIf[g].addrVal = aval_reg[g];
		assign wpIf[g].addrMask = amsk_reg[g];
		assign wpIf[g].dataVal = dval_reg[g];
		assign wpIf[g].dataMask = dmsk_reg[g];
		assign wpIf[g].ctrlVal = cval_reg[g];
		assign wpIf[g].ctrlMask = cmsk_reg[g];
		assign wpIf[g].enable = cfg_reg[g][`DHW_CFG_EN];
		assign wpIf[g].fetchMode = cfg_reg[g][`DHW_CFG_FETCH];
		assign unitHit[g] = wpIf[g].match;
		dhw_wp_match #(.AW(AW), .DW(DW), .CW(CW)) uMatch (
			.accValid(accValid),
			.accFetch(accFetch),
			.accAddr(accAddr),
			.accData(accData),
			.accCtrl(accCtrl),
			.cfg(wpIf[g].unit)
		);
	end

	// tag only from the units, dropped in debug state
	assign running = (state_reg == DHW_RUN);
	assign breakpoint_tag_in = running & (|unitHit);
	assign debug_acknowledge_out = (state_reg == DHW_HALT);

	// ****************************************
	// register read mux
	// ****************************************
	always_comb begin
		statusWord = `DHW_RST_WORD;
		statusWord[`DHW_STAT_DBG] = debug_acknowledge_out;
		statusWord[`DHW_STAT_CAUSE_LO +: 2] = cause_reg;
		statusWord[`DHW_STAT_REQ] = haltReq;
		statusWord[`DHW_STAT_DPEND] = dataPend_reg;
	end

	function automatic logic [31:0] regRead(input logic [7:0] a);
		logic [31:0] r;
		logic ui;
		r = `DHW_RST_WORD;
		ui = a[5];
		if (a[7:6] == `DHW_UNIT_REGION) begin
			case (a[4:0])
				`DHW_OFS_AVAL: r = 32'(aval_reg[ui]);
				`DHW_OFS_AMSK: r = 32'(amsk_reg[ui]);
				`DHW_OFS_DVAL: r = 32'(dval_reg[ui]);
				`DHW_OFS_DMSK: r = 32'(dmsk_reg[ui]);
				`DHW_OFS_CVAL: r = 32'(cval_reg[ui]);
				`DHW_OFS_CMSK: r = 32'(cmsk_reg[ui]);
				`DHW_OFS_CFG: r = 32'(cfg_reg[ui]);
				default: r = `DHW_RST_WORD;
			endcase
		end else begin
			case (a)
				`DHW_OFS_CTRL: r = 32'(ctrlHalt_reg);
				`DHW_OFS_STAT: r = statusWord;
				`DHW_OFS_IRQ_STAT: r = 32'(irqStat_reg);
				`DHW_OFS_IRQ_MASK: r = 32'(irqMask_reg);
				default: r = `DHW_RST_WORD;
			endcase
		end
		return r;
	endfunction

	// ****************************************
	// pin synchronisers and test port edge
	// ****************************************
	always_comb begin
		pinMeta_next = {debug_request_in, jtagTdi, jtagTms, jtagTck};
		pinSync_next = pinMeta_reg;
		tckPrev_next = pinSync_reg[0];
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			pinMeta_reg <= 4'h0;
			pinSync_reg <= 4'h0;
			tckPrev_reg <= 1'b0;
		end else begin
			pinMeta_reg <= pinMeta_next;
			pinSync_reg <= pinSync_next;
			tckPrev_reg <= tckPrev_next;
		end
	end

	assign tckRise = pinSync_reg[0] & ~tckPrev_reg;
	assign dbgReqSync = pinSync_reg[3];
	assign haltReq = dbgReqSync | ctrlHalt_reg;

	// ****************************************
	// bus slave and shared write port
	// ****************************************
	assign avs_waitrequest = (avs_read | avs_write) & ~avAck_reg;
	assign avs_readdata = rdata_reg;
	assign avWr = avs_write & avAck_reg;
	assign jtAddr = jtCmd_reg[`DHW_SCAN_ADDR_LO +: 8];
	assign jtWr = jtPend_reg & ~avWr & ~tckRise;
	assign wrEn = avWr | (jtWr & jtCmd_reg[`DHW_SCAN_WR]);
	assign wrAddr = avWr ? avs_address : jtAddr;
	assign wrData = avWr ? avs_writedata : jtCmd_reg[`DHW_SCAN_DATA_LO +: 32];
	assign resumeReq = wrEn & (wrAddr == `DHW_OFS_CTRL)
		& wrData[`DHW_CTRL_RESUME];

	// answer one cycle after the request is seen
	always_comb begin
		avAck_next = (avs_read | avs_write) & ~avAck_reg;
		rdata_next = rdata_reg;
		if (avs_read & ~avAck_reg) begin
			rdata_next = regRead(avs_address);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			avAck_reg <= 1'b0;
			rdata_reg <= `DHW_RST_WORD;
		end else begin
			avAck_reg <= avAck_next;
			rdata_reg <= rdata_next;
		end
	end

	// ****************************************
	// serial scan: shift while mode low, act on mode high
	// ****************************************
	always_comb begin
		scan_next = scan_reg;
		jtCmd_next = jtCmd_reg;
		jtPend_next = jtPend_reg;
		if (tckRise) begin
			if (!pinSync_reg[1]) begin
				scan_next = {pinSync_reg[2], scan_reg[`DHW_SCAN_W-1:1]};
			end else begin
				jtCmd_next = scan_reg;
				jtPend_next = 1'b1;
			end
		end else if (jtWr) begin
			jtPend_next = 1'b0;
			scan_next = {regRead(jtAddr), jtAddr, 1'b0};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			scan_reg <= '0;
			jtCmd_reg <= '0;
			jtPend_reg <= 1'b0;
		end else begin
			scan_reg <= scan_next;
			jtCmd_reg <= jtCmd_next;
			jtPend_reg <= jtPend_next;
		end
	end

	assign jtagTdo = scan_reg[0];

	// ****************************************
	// watchpoint and control registers
	// ****************************************
	always_comb begin
		for (int u = 0; u < NU; u++) begin
			aval_next[u] = aval_reg[u];
			amsk_next[u] = amsk_reg[u];
			dval_next[u] = dval_reg[u];
			dmsk_next[u] = dmsk_reg[u];
			cval_next[u] = cval_reg[u];
			cmsk_next[u] = cmsk_reg[u];
			cfg_next[u] = cfg_reg[u];
			if (wrEn && wrAddr[7:6] == `DHW_UNIT_REGION
				&& wrAddr[5] == u[0]) begin
				case (wrAddr[4:0])
					`DHW_OFS_AVAL: aval_next[u] = wrData[AW-1:0];
					`DHW_OFS_AMSK: amsk_next[u] = wrData[AW-1:0];
					`DHW_OFS_DVAL: dval_next[u] = wrData[DW-1:0];
					`DHW_OFS_DMSK: dmsk_next[u] = wrData[DW-1:0];
					`DHW_OFS_CVAL: cval_next[u] = wrData[CW-1:0];
					`DHW_OFS_CMSK: cmsk_next[u] = wrData[CW-1:0];
					`DHW_OFS_CFG: cfg_next[u] = wrData[1:0];
					default: cfg_next[u] = cfg_reg[u];
				endcase
			end
		end
		ctrlHalt_next = ctrlHalt_reg;
		irqMask_next = irqMask_reg;
		irqClr = '0;
		if (wrEn && wrAddr == `DHW_OFS_CTRL) begin
			ctrlHalt_next = wrData[`DHW_CTRL_HALT];
		end
		if (wrEn && wrAddr == `DHW_OFS_IRQ_MASK) begin
			irqMask_next = wrData[`DHW_IRQ_W-1:0];
		end
		if (wrEn && wrAddr == `DHW_OFS_IRQ_STAT) begin
			irqClr = wrData[`DHW_IRQ_W-1:0];
		end
		// a new event beats a clear in the same cycle
		irqSet = {enterEvt, unitHit & {NU{running}}};
		irqStat_next = (irqStat_reg & ~irqClr) | irqSet;
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			for (int u = 0; u < NU; u++) begin
				aval_reg[u] <= '0;
				amsk_reg[u] <= '0;
				dval_reg[u] <= '0;
				dmsk_reg[u] <= '0;
				cval_reg[u] <= '0;
				cmsk_reg[u] <= '0;
				cfg_reg[u] <= `DHW_RST_CFG;
			end
			ctrlHalt_reg <= 1'b0;
			irqStat_reg <= `DHW_RST_IRQ;
			irqMask_reg <= `DHW_RST_IRQ;
		end else begin
			aval_reg <= aval_next;
			amsk_reg <= amsk_next;
			dval_reg <= dval_next;
			dmsk_reg <= dmsk_next;
			cval_reg <= cval_next;
			cmsk_reg <= cmsk_next;
			cfg_reg <= cfg_next;
			ctrlHalt_reg <= ctrlHalt_next;
			irqStat_reg <= irqStat_next;
			irqMask_reg <= irqMask_next;
		end
	end

	assign irq = |(irqStat_reg & irqMask_reg);

	// ****************************************
	// debug state entry and exit
	// ****************************************
	assign newFetch = breakpoint_tag_in & accValid & accFetch;
	assign newData = breakpoint_tag_in & accValid & ~accFetch;

	always_comb begin
		state_next = state_reg;
		cause_next = cause_reg;
		tagPipe_next = tagPipe_reg;
		dataPend_next = dataPend_reg;
		enterEvt = 1'b0;
		case (state_reg)
			DHW_RUN: begin
				// tag follows its instruction; a flush drops it
				if (pipeFlush) begin
					tagPipe_next = 3'h0;
				end else if (pipeAdvance) begin
					tagPipe_next = {tagPipe_reg[1:0], newFetch};
				end else begin
					tagPipe_next = tagPipe_reg | {2'h0, newFetch};
				end
				dataPend_next = dataPend_reg | newData;
				if (tagPipe_reg[2]) begin
					enterEvt = 1'b1;
					cause_next = DHW_CAUSE_FETCH;
				end else if (instrDone && (dataPend_reg || newData)) begin
					enterEvt = 1'b1;
					cause_next = DHW_CAUSE_DATA;
				end else if (instrDone && haltReq) begin
					enterEvt = 1'b1;
					cause_next = DHW_CAUSE_REQ;
				end
				if (enterEvt) begin
					state_next = DHW_HALT;
					tagPipe_next = 3'h0;
					dataPend_next = 1'b0;
				end
			end
			DHW_HALT: begin
				if (resumeReq) begin
					state_next = DHW_RUN;
				end
			end
			default: begin
				state_next = DHW_RUN;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			state_reg <= DHW_RUN;
			cause_reg <= DHW_CAUSE_NONE;
			tagPipe_reg <= 3'h0;
			dataPend_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cause_reg <= cause_next;
			tagPipe_reg <= tagPipe_next;
			dataPend_reg <= dataPend_next;
		end
	end

endmodule

// >>> verif/dhw_debug_unit_asserts.sv
`timescale 1ns/100ps
// ****************************************
// port checks of the debug unit
// ****************************************
module dhw_debug_unit_asserts (
	input wire logic ref_clk, // block clock
	input wire logic reset_n, // synchronous reset
	input wire logic [7:0] avs_address, // byte address
	input wire logic avs_read, // read strobe
	input wire logic avs_write, // write strobe
	input wire logic [31:0] avs_writedata, // write data
	input wire logic avs_waitrequest, // stall
	input wire logic irq, // level interrupt
	input wire logic accValid, // core access valid
	input wire logic accFetch, // access is a fetch
	input wire logic pipeAdvance, // pipeline step
	input wire logic instrDone, // instruction completes
	input wire logic debug_request_in, // outside halt request
	input wire logic breakpoint_tag_in, // tag toward the core
	input wire logic debug_acknowledge_out // core halted
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	// halted core shows no tag
	AST_NO_TAG_HALTED: assert property (
		debug_acknowledge_out |-> !breakpoint_tag_in)
		else $error("tag while halted");
	// tag only during an access
	AST_TAG_ACCESS: assert property (
		breakpoint_tag_in |-> accValid)
		else $error("tag without access");
	// leaving debug state needs a resume write
	AST_ACK_HOLD: assert property (
		$fell(debug_acknowledge_out) |-> $past(avs_write
		&& !avs_waitrequest && avs_address == 8'h40 && avs_writedata[1]))
		else $error("debug state left without resume");
	// entry only at completion or after the fetch reaches execute
	AST_ENTRY_CAUSE: assert property (
		$rose(debug_acknowledge_out)
		|-> $past(instrDone) || $past(pipeAdvance, 2))
		else $error("debug entry at wrong point");
	// tagged data access halts at completion
	AST_DATA_HALT: assert property (
		breakpoint_tag_in && !accFetch && instrDone
		|=> debug_acknowledge_out)
		else $error("data tag did not halt");
	// held request halts at completion
	AST_REQ_HALT: assert property (
		debug_request_in [*4] ##1
		(debug_request_in && instrDone && !debug_acknowledge_out)
		|=> debug_acknowledge_out)
		else $error("request did not halt");
	// interrupt rises only after an event or a register write
	AST_IRQ_CAUSE: assert property (
		$rose(irq) |-> $past(breakpoint_tag_in) || debug_acknowledge_out
		|| $past(avs_write))
		else $error("interrupt without event");
	// bus answers in the second cycle
	AST_WAIT_ONE: assert property (
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");
	// no stall without a request
	AST_IDLE_NOWAIT: assert property (
		!avs_read && !avs_write |-> !avs_waitrequest)
		else $error("stall while idle");
endmodule

bind dhw_debug_unit dhw_debug_unit_asserts i_chk (.ref_clk, .reset_n,
	.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_waitrequest,
	.irq, .accValid, .accFetch, .pipeAdvance, .instrDone, .debug_request_in,
	.breakpoint_tag_in, .debug_acknowledge_out);

// >>> verif/dhw_jtag_host.sv
`timescale 1ns/100ps
// ****************************************
// serial converter standing for the host debugger
// ****************************************
module dhw_jtag_host (
	output logic jtagTck, // test port clock
	output logic jtagTms, // mode select
	output logic jtagTdi, // data toward the block
	input wire logic jtagTdo // data from the block
);
	// clock stands low between frames
	initial begin
		jtagTck = 1'b0;
		jtagTms = 1'b0;
		jtagTdi = 1'b0;
	end
	// one message: 41 shifts lsb first, one update rise, 48 ns clock
	task automatic frame(input logic [40:0] cmd,
		output logic [40:0] seen);
		for (int i = 0; i < 41; i++) begin
			jtagTms = 1'b0;
			jtagTdi = cmd[i];
			#24;
			seen[i] = jtagTdo;
			jtagTck = 1'b1;
			#24;
			jtagTck = 1'b0;
		end
		jtagTms = 1'b1;
		#24;
		jtagTck = 1'b1;
		#24;
		jtagTck = 1'b0;
		jtagTms = 1'b0;
		jtagTdi = ~jtagTdi; // released line must not keep its value
		#96;
	endtask
endmodule

// >>> verif/test_dhw_debug_unit.sv
`timescale 1ns/100ps
module test_dhw_debug_unit;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0, avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
	logic avs_waitrequest, irq, jtagTck, jtagTms, jtagTdi, jtagTdo;
	logic accValid = 1'b0, accFetch = 1'b0, pipeAdvance = 1'b0;
	logic pipeFlush = 1'b0, instrDone = 1'b0, debug_request_in = 1'b0;
	logic [31:0] accAddr = 32'h0, accData = 32'h0;
	logic [3:0] accCtrl = 4'h0;
	logic breakpoint_tag_in, debug_acknowledge_out, tagv;
	logic [40:0] seen;
	int fails = 0, n_compared = 0;

	// 200 MHz clock
	always #2.5 ref_clk = ~ref_clk;

	dhw_debug_unit i_dut (.ref_clk, .reset_n, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .irq,
		.jtagTck, .jtagTms, .jtagTdi, .jtagTdo, .accValid, .accFetch,
		.accAddr, .accData, .accCtrl, .pipeAdvance, .pipeFlush, .instrDone,
		.debug_request_in, .breakpoint_tag_in, .debug_acknowledge_out);
	dhw_jtag_host i_host (.jtagTck, .jtagTms, .jtagTdi, .jtagTdo);

	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, got);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one bus cycle, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 20) begin
			fails++;
			stop_test();
		end
	endtask

	// one core access, tag sampled mid-cycle
	task automatic acc(input logic f, input logic [31:0] a, d,
		input logic [3:0] c);
		@(posedge ref_clk);
		{accValid, accFetch, accAddr, accData, accCtrl} <= {1'b1, f, a, d, c};
		@(negedge ref_clk);
		tagv = breakpoint_tag_in;
		@(posedge ref_clk);
		accValid <= 1'b0;
	endtask

	// pipeline pulse: advance, flush, done
	task automatic pulse(input logic [2:0] k);
		@(posedge ref_clk);
		{pipeAdvance, pipeFlush, instrDone} <= k;
		@(posedge ref_clk);
		{pipeAdvance, pipeFlush, instrDone} <= 3'h0;
	endtask

	task automatic wait_ack(input int lim, input logic exp, input string what);
		int n;
		n = 0;
		while (debug_acknowledge_out !== exp && n < lim) begin
			@(negedge ref_clk);
			n++;
		end
		chk(what, {31'h0, exp}, {31'h0, debug_acknowledge_out});
	endtask

	task automatic prog(input logic [7:0] b, input logic [31:0] a, am,
		d, dm, input logic [1:0] cfg);
		bus(1'b1, b, a);
		bus(1'b1, b + 8'h04, am);
		bus(1'b1, b + 8'h08, d);
		bus(1'b1, b + 8'h0c, dm);
		bus(1'b1, b + 8'h10, 32'h3);
		bus(1'b1, b + 8'h14, 32'h0);
		bus(1'b1, b + 8'h18, {30'h0, cfg});
	endtask

	task automatic resume;
		pulse(3'h2);
		bus(1'b1, 8'h40, 32'h2);
		wait_ack(4, 1'b0, "resume");
	endtask

	task automatic s_regs;
		bus(1'b0, 8'h00, 32'h0);
		chk("addrVal reset", 32'h0, rd);
		bus(1'b1, 8'h24, 32'h5a5a_00f0);
		bus(1'b0, 8'h24, 32'h0);
		chk("unit1 addrMask", 32'h5a5a_00f0, rd);
		bus(1'b1, 8'h80, 32'hffff_ffff);
		bus(1'b0, 8'h80, 32'h0);
		chk("unmapped", 32'h0, rd);
	endtask

	task automatic s_fetch;
		prog(8'h00, 32'h100, 32'h0, 32'h0, 32'hffff_ffff, 2'h3);
		acc(1'b1, 32'h100, 32'h1234, 4'h3);
		chk("fetch tag", 32'h1, {31'h0, tagv});
		acc(1'b1, 32'h104, 32'h0, 4'h3);
		chk("addr miss", 32'h0, {31'h0, tagv});
		acc(1'b1, 32'h100, 32'h0, 4'h2);
		chk("ctrl miss", 32'h0, {31'h0, tagv});
		acc(1'b0, 32'h100, 32'h0, 4'h3);
		chk("data in fetch mode", 32'h0, {31'h0, tagv});
		bus(1'b1, 8'h04, 32'h4);
		acc(1'b1, 32'h104, 32'h0, 4'h3);
		chk("masked bit", 32'h1, {31'h0, tagv});
		// the flush drops the tag, so two steps must not halt
		pulse(3'h2);
		pulse(3'h4);
		pulse(3'h4);
		repeat (6) @(negedge ref_clk);
		chk("flushed fetch", 32'h0, {31'h0, debug_acknowledge_out});
		acc(1'b1, 32'h104, 32'h0, 4'h3);
		pulse(3'h4);
		chk("one stage", 32'h0, {31'h0, debug_acknowledge_out});
		pulse(3'h4);
		wait_ack(4, 1'b1, "fetch halt");
		acc(1'b1, 32'h104, 32'h0, 4'h3);
		chk("tag halted", 32'h0, {31'h0, tagv});
		pulse(3'h1);
		bus(1'b0, 8'h44, 32'h0);
		chk("fetch cause", 32'h3, rd & 32'h7);
		chk("irq masked", 32'h0, {31'h0, irq});
		bus(1'b1, 8'h4c, 32'h4);
		@(negedge ref_clk);
		chk("irq entry", 32'h1, {31'h0, irq});
		bus(1'b1, 8'h48, 32'h7);
		@(negedge ref_clk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		resume();
	endtask

	task automatic s_data;
		prog(8'h20, 32'h200, 32'h0, 32'ha5, 32'h0, 2'h1);
		acc(1'b0, 32'h200, 32'ha4, 4'h3);
		chk("data miss", 32'h0, {31'h0, tagv});
		acc(1'b0, 32'h200, 32'ha5, 4'h3);
		chk("unit1 tag", 32'h1, {31'h0, tagv});
		repeat (4) @(posedge ref_clk);
		chk("before done", 32'h0, {31'h0, debug_acknowledge_out});
		pulse(3'h1);
		wait_ack(4, 1'b1, "data halt");
		bus(1'b0, 8'h44, 32'h0);
		chk("data cause", 32'h5, rd & 32'h7);
		resume();
	endtask

	task automatic s_req;
		@(posedge ref_clk);
		debug_request_in <= 1'b1;
		repeat (6) @(posedge ref_clk);
		chk("request waits", 32'h0, {31'h0, debug_acknowledge_out});
		pulse(3'h1);
		wait_ack(4, 1'b1, "request halt");
		bus(1'b0, 8'h44, 32'h0);
		chk("request cause", 32'h7, rd & 32'h7);
		debug_request_in <= 1'b0;
		repeat (4) @(posedge ref_clk);
		resume();
		pulse(3'h1);
		repeat (3) @(posedge ref_clk);
		chk("no cause", 32'h0, {31'h0, debug_acknowledge_out});
		// software halt bit acts like the pin request
		bus(1'b1, 8'h40, 32'h1);
		pulse(3'h1);
		wait_ack(4, 1'b1, "soft halt");
		bus(1'b0, 8'h40, 32'h0);
		chk("halt bit", 32'h1, rd);
		resume();
	endtask

	task automatic s_scan;
		i_host.frame({32'hcafe_0001, 8'h08, 1'b1}, seen);
		bus(1'b0, 8'h08, 32'h0);
		chk("scan write", 32'hcafe_0001, rd);
		i_host.frame({32'h0, 8'h08, 1'b0}, seen);
		chk("old value", 32'h0, seen[40:9]);
		i_host.frame({32'h0, 8'h08, 1'b0}, seen);
		chk("scan read", 32'hcafe_0001, seen[40:9]);
		chk("scan addr", 32'h8, {24'h0, seen[8:1]});
	endtask

	initial begin
		repeat (20) @(posedge ref_clk);
		reset_n <= 1'b1;
		s_regs();
		s_fetch();
		s_data();
		s_req();
		s_scan();
		stop_test();
	end
endmodule
